// file: rtl/dpmbx_pkg.sv
// constants and types for the dual-port memory host controller
package dpmbx_pkg;
   localparam int          ADDR_W          = 13;
   localparam int          DATA_W          = 9;
   localparam logic [12:0] MBX_TO_RIGHT    = 13'h1fff;
   localparam logic [12:0] MBX_TO_LEFT     = 13'h1ffe;
   localparam int          TOKEN_COUNT     = 8;
   localparam int          CLK_PERIOD_NS   = 40;
   // access strobe width and gaps, ns
   localparam int          STROBE_NS       = 60;
   localparam int          CROSS_PORT_DELAY_NS  = 40;
   localparam int          TOKEN_RELEASE_GAP_NS = 20;
   localparam int          STROBE_CYC      = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          XPORT_CYC       =
      (CROSS_PORT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          GAP_CYC         =
      (TOKEN_RELEASE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          CNT_W           = 4;
   // command codes on the user side
   localparam logic [1:0]  CMD_MEM_RD      = 2'h0;
   localparam logic [1:0]  CMD_MEM_WR      = 2'h1;
   localparam logic [1:0]  CMD_TOK_WR      = 2'h2;
   localparam logic [1:0]  CMD_TOK_RD      = 2'h3;
   typedef enum logic [2:0] {DPMBX_IDLE, DPMBX_SETUP, DPMBX_STROBE, DPMBX_GAP, DPMBX_DONE}
      dpmbx_state_t;
endpackage : dpmbx_pkg

// file: rtl/dpmbx_host.sv
// host-side access controller for one port of the dual-port mailbox memory
`timescale 1ns/1ps
// Behaviour
// - writer to slave waits for settled busy before writing; the strobe is not stretched, wr_b stays high while busy is low.
// - reading needs chip select and output enable both low.
// - token access uses token select with chip select high; never both.
// - reading a location the other port writes waits cross-port delay.
// - after token write, deselect for release gap before readback.
// - software writes 1 to every token from both sides at start; the controller writes all eight from this side only, on init_tokens.
// - write happens while select and write strobe are both low.
module dpmbx_host #(
   parameter int DW = dpmbx_pkg::DATA_W
) (
   // clock and reset
   input  wire logic                         sys_clk,
   input  wire logic                         rst_b,
   // user command side
   input  wire logic                         cmd_valid,
   output logic                              cmd_ready,
   input  wire logic [1:0]                   cmd_op,
   input  wire logic [dpmbx_pkg::ADDR_W-1:0] cmd_addr,
   input  wire logic [DW-1:0]                cmd_wdata,
   output logic                              rsp_valid,
   output logic [DW-1:0]                     rsp_rdata,
   output logic                              rsp_busy_hit,
   output logic                              mbx_pending,
   input  wire logic                         init_tokens,
   // device port pins
   output logic [dpmbx_pkg::ADDR_W-1:0]      mem_addr,
   output logic                              chip_sel_b,
   output logic                              token_sel_b,
   output logic                              wr_b,
   output logic                              out_en_b,
   input  wire logic [DW-1:0]                data_in,
   output logic [DW-1:0]                     data_out,
   output logic                              data_oe,
   input  wire logic                         busy_b,
   input  wire logic                         mbx_flag_b
);
   import dpmbx_pkg::*;

   // the pins carry eight or nine data lines, nothing else
   if (DW != 8 && DW != 9) begin : g_bad_width
      $error("data width must be 8 or 9");
   end

   // ----------------------------------------------------------------
   // reset release and pin synchronisers
   // ----------------------------------------------------------------
   logic [1:0]     rst_sync_q;
   logic           rst_n;
   logic [2:0]     busy_sync_q, flag_sync_q;
   logic           busy_q, flag_q;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) rst_sync_q <= 2'h0;
      else rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_n = rst_sync_q[1];

   // a level is trusted once stages two and three agree; busy idles high
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_sync_q <= 3'h7;
         flag_sync_q <= 3'h7;
         busy_q      <= 1'b1;
         flag_q      <= 1'b1;
      end else begin
         busy_sync_q <= {busy_sync_q[1:0], busy_b};
         flag_sync_q <= {flag_sync_q[1:0], mbx_flag_b};
         if (busy_sync_q[1] == busy_sync_q[2]) busy_q <= busy_sync_q[2];
         if (flag_sync_q[1] == flag_sync_q[2]) flag_q <= flag_sync_q[2];
      end
   end
   assign mbx_pending = ~flag_q;

   // ----------------------------------------------------------------
   // access sequencer
   // ----------------------------------------------------------------
   dpmbx_state_t      st_q, st_d;
   logic [CNT_W-1:0]  cnt_q, cnt_d;
   logic [1:0]        op_q, op_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [DW-1:0]     wdat_q, wdat_d, rdat_q, rdat_d;
   logic              busy_hit_q, busy_hit_d;
   logic              init_q, init_d;
   logic [2:0]        init_idx_q, init_idx_d;

   function automatic logic is_token(input logic [1:0] op);
      return op == CMD_TOK_WR || op == CMD_TOK_RD;
   endfunction : is_token

   function automatic logic is_write(input logic [1:0] op);
      return op == CMD_MEM_WR || op == CMD_TOK_WR;
   endfunction : is_write

   always_comb begin
      st_d       = st_q;
      cnt_d      = cnt_q;
      op_d       = op_q;
      addr_d     = addr_q;
      wdat_d     = wdat_q;
      rdat_d     = rdat_q;
      busy_hit_d = busy_hit_q;
      init_d     = init_q;
      init_idx_d = init_idx_q;
      case (st_q)
         DPMBX_IDLE: begin
            busy_hit_d = 1'b0;
            if (init_tokens || init_q) begin
               // free every token from this side
               op_d   = CMD_TOK_WR;
               addr_d = {{(ADDR_W-3){1'b0}}, init_idx_q};
               wdat_d = {{(DW-1){1'b0}}, 1'b1};
               init_d = 1'b1;
               st_d   = DPMBX_SETUP;
            end else if (cmd_valid) begin
               op_d   = cmd_op;
               addr_d = is_token(cmd_op) ? {{(ADDR_W-3){1'b0}}, cmd_addr[2:0]} : cmd_addr;
               wdat_d = is_token(cmd_op) ? {{(DW-1){1'b0}}, cmd_wdata[0]} : cmd_wdata;
               st_d   = DPMBX_SETUP;
            end
         end
         DPMBX_SETUP: begin
            // address settles before the select falls, so busy can settle too
            cnt_d = CNT_W'(STROBE_CYC);
            st_d  = DPMBX_STROBE;
         end
         DPMBX_STROBE: begin
            if (op_q == CMD_MEM_WR && !busy_q) begin
               busy_hit_d = 1'b1;
            end
            if (cnt_q > CNT_W'(1)) begin
               cnt_d = cnt_q - CNT_W'(1);
            end else begin
               // data sampled at the end of the strobe
               if (!is_write(op_q)) rdat_d = data_in;
               cnt_d = is_token(op_q) ? CNT_W'(GAP_CYC) : CNT_W'(XPORT_CYC);
               st_d  = DPMBX_GAP;
            end
         end
         DPMBX_GAP: begin
            // deselected pause before any following access
            if (cnt_q > CNT_W'(1)) cnt_d = cnt_q - CNT_W'(1);
            else st_d = DPMBX_DONE;
         end
         DPMBX_DONE: begin
            if (init_q) begin
               init_idx_d = init_idx_q + 3'h1;
               if (init_idx_q == 3'(TOKEN_COUNT - 1)) init_d = 1'b0;
            end
            st_d = DPMBX_IDLE;
         end
         default: st_d = DPMBX_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q       <= DPMBX_IDLE;
         cnt_q      <= '0;
         op_q       <= CMD_MEM_RD;
         addr_q     <= '0;
         wdat_q     <= '0;
         rdat_q     <= '0;
         busy_hit_q <= 1'b0;
         init_q     <= 1'b0;
         init_idx_q <= 3'h0;
      end else begin
         st_q       <= st_d;
         cnt_q      <= cnt_d;
         op_q       <= op_d;
         addr_q     <= addr_d;
         wdat_q     <= wdat_d;
         rdat_q     <= rdat_d;
         busy_hit_q <= busy_hit_d;
         init_q     <= init_d;
         init_idx_q <= init_idx_d;
      end
   end

   // ----------------------------------------------------------------
   // pin drive
   // ----------------------------------------------------------------
   logic strobe;
   assign strobe      = (st_q == DPMBX_STROBE);
   assign mem_addr    = addr_q;
   // only one select is ever low
   assign chip_sel_b  = ~(strobe && !is_token(op_q));
   assign token_sel_b = ~(strobe && is_token(op_q));
   // a busy slave write keeps its strobe high while busy has not settled high, and only for the fixed strobe length
   assign wr_b        = ~(strobe && is_write(op_q) && (busy_q || is_token(op_q)));
   assign out_en_b    = ~(strobe && !is_write(op_q));
   assign data_out    = wdat_q;
   assign data_oe     = strobe && is_write(op_q);
   // nothing is taken while the internal reset still holds the sequencer
   assign cmd_ready   = rst_n && (st_q == DPMBX_IDLE) && !init_tokens && !init_q;
   assign rsp_valid   = (st_q == DPMBX_DONE) && !init_q;
   assign rsp_rdata   = rdat_q;
   assign rsp_busy_hit = busy_hit_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   chk_sel_exclusive: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !(!chip_sel_b && !token_sel_b)) else $error("both selects low");
   chk_read_enables: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !out_en_b |-> (!chip_sel_b || !token_sel_b) && wr_b) else $error("read without select");
   chk_write_overlap: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !wr_b |-> (!chip_sel_b || !token_sel_b) && out_en_b) else $error("write without select");
   chk_data_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !wr_b |-> data_oe) else $error("write without data drive");
   chk_busy_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!chip_sel_b && !busy_q) |-> wr_b) else $error("write during busy");
   chk_token_gap: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $rose(token_sel_b) |-> token_sel_b [*2]) else $error("token gap too short");
   chk_token_addr: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !token_sel_b |-> mem_addr[ADDR_W-1:3] == '0) else $error("token address high bits");
   chk_rsp_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rsp_valid |-> $stable(rsp_rdata)) else $error("read data moved at answer");
   chk_strobe_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $fell(chip_sel_b) |-> !chip_sel_b [*2] ##1 chip_sel_b) else $error("strobe length");
   cov_mem_write: cover property (@(posedge sys_clk) !chip_sel_b && !wr_b);
   cov_token_read: cover property (@(posedge sys_clk) !token_sel_b && !out_en_b);
   cov_busy_stall: cover property (@(posedge sys_clk) !chip_sel_b && !busy_q && wr_b);
   cov_mbx_flag: cover property (@(posedge sys_clk) mbx_pending);

endmodule : dpmbx_host

// file: dv/dpmbx_dev_model.sv
// behavioural model of the shared memory device seen from its left port
`timescale 1ns/1ps
module dpmbx_dev_model
   import dpmbx_pkg::*;
(
   // left port pins
   input  wire logic [ADDR_W-1:0] mem_addr,
   input  wire logic              chip_sel_b,
   input  wire logic              token_sel_b,
   input  wire logic              wr_b,
   input  wire logic              out_en_b,
   input  wire logic [DATA_W-1:0] wr_data,
   // answers to the left port
   output logic [DATA_W-1:0]      rd_data,
   output logic                   busy_b,
   output logic                   mbx_flag_b
);
   logic [DATA_W-1:0] mem [0:8191];
   logic [7:0]        own [2] = '{8'hff, 8'h00};
   logic [7:0]        req [2] = '{8'h00, 8'h00};
   logic              left_flag_b = 1'b1, right_flag_b = 1'b1, busy_in_b = 1'b1;
   logic              illegal = 1'b0, gap_bad = 1'b0, is_tok = 1'b0, tok_q = 1'b0;
   logic              busy_wr = 1'b0;
   logic [DATA_W-1:0] last_q = '0;
   realtime           t_wr = -1.0e6;
   wire               wr_act = ~wr_b & (~chip_sel_b | ~token_sel_b);
   wire               rd_mem = ~chip_sel_b & ~out_en_b & wr_b & token_sel_b;
   wire               rd_tok = ~token_sel_b & ~out_en_b & wr_b & chip_sel_b;
   wire [2:0]         ti = mem_addr[2:0];
   wire [DATA_W-1:0]  drv = rd_mem ? mem[mem_addr] : {DATA_W{tok_q}};
   // slave role: busy arrives from the master, played by the bench
   // the bench plays the master and hands this port the arbitration outcome
   assign busy_b     = busy_in_b;
   assign mbx_flag_b = left_flag_b;
   // a released bus shows the inverse of its last value, never a stale copy
   assign rd_data    = (rd_mem | rd_tok) ? drv : ~last_q;
   always @* if (rd_mem | rd_tok) last_q = drv;
   always @* if (!chip_sel_b && !token_sel_b) illegal = 1'b1;
   always @(posedge wr_act) is_tok = ~token_sel_b;
   always @(negedge wr_act) begin
      t_wr = $realtime;
      if (is_tok) tok_wr(0, ti, wr_data[0]);
      else if (!busy_in_b) busy_wr = 1'b1;
      else begin
         mem[mem_addr] = wr_data;
         if (mem_addr == MBX_TO_RIGHT) right_flag_b = 1'b0;
      end
   end
   // frozen at read start so a far-side write cannot tear the value
   always @(posedge rd_tok) begin
      tok_q = ~own[0][ti];
      if ($realtime - t_wr < TOKEN_RELEASE_GAP_NS) gap_bad = 1'b1;
   end
   always @(posedge rd_mem) if (mem_addr == MBX_TO_LEFT) left_flag_b = 1'b1;
   task automatic tok_wr(input int s, input int i, input logic bit0);
      req[s][i] = ~bit0;
      if (bit0 && own[s][i]) begin
         own[s][i] = 1'b0;
         own[1-s][i] = req[1-s][i];
      end else if (!bit0 && !own[1-s][i]) begin
         own[s][i] = 1'b1;
      end
   endtask : tok_wr
   task automatic right_mem_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      mem[a] = d;
      if (a == MBX_TO_LEFT) left_flag_b = 1'b0;
   endtask : right_mem_wr
   task automatic right_mem_rd(input logic [ADDR_W-1:0] a);
      if (a == MBX_TO_RIGHT) right_flag_b = 1'b1;
   endtask : right_mem_rd
endmodule : dpmbx_dev_model

// file: dv/dpmbx_host_tb_top.sv
// self-checking bench for the host controller against the device model
`timescale 1ns/1ps
module dpmbx_host_tb_top;
   import dpmbx_pkg::*;
   logic              sys_clk = 1'b0, rst_b = 1'b1, cmd_valid = 1'b0, init_tokens = 1'b0;
   logic [1:0]        cmd_op = 2'h0;
   logic [ADDR_W-1:0] cmd_addr = 13'h0000, mem_addr;
   logic [DATA_W-1:0] cmd_wdata = 9'h000, rsp_rdata, data_in, data_out;
   logic              cmd_ready, rsp_valid, rsp_busy_hit, mbx_pending, chip_sel_b;
   logic              token_sel_b, wr_b, out_en_b, data_oe, busy_b, mbx_flag_b;
   logic [ADDR_W-1:0] ads [3] = '{13'h0000, 13'h1ffd, 13'h0aaa};
   int                n_errors = 0, total_checks = 0;
   always #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
   dpmbx_host #(.DW(DATA_W)) dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_busy_hit(rsp_busy_hit),
      .mbx_pending(mbx_pending), .init_tokens(init_tokens), .mem_addr(mem_addr),
      .chip_sel_b(chip_sel_b), .token_sel_b(token_sel_b), .wr_b(wr_b), .out_en_b(out_en_b),
      .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .busy_b(busy_b),
      .mbx_flag_b(mbx_flag_b));
   dpmbx_dev_model dev_u (.mem_addr(mem_addr), .chip_sel_b(chip_sel_b), .token_sel_b(token_sel_b),
      .wr_b(wr_b), .out_en_b(out_en_b), .wr_data(data_out), .rd_data(data_in),
      .busy_b(busy_b), .mbx_flag_b(mbx_flag_b));
   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic do_cmd(input logic [1:0] op, input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] d);
      int n;
      for (n = 0; n < 300 && cmd_ready !== 1'b1; n++) @(negedge sys_clk);
      @(posedge sys_clk);
      cmd_valid <= 1'b1;
      cmd_op    <= op;
      cmd_addr  <= a;
      cmd_wdata <= d;
      @(posedge sys_clk);
      cmd_valid <= 1'b0;
      n = 0;
      do begin
         @(negedge sys_clk);
         n++;
      end while (rsp_valid !== 1'b1 && n < 20);
      check(9'(rsp_valid), 9'h001);
   endtask : do_cmd
   task automatic wait_pend(input logic exp);
      int n;
      for (n = 0; n < 12 && mbx_pending !== exp; n++) @(negedge sys_clk);
      check(9'(mbx_pending), 9'(exp));
   endtask : wait_pend
   task automatic tok_chk(input int i, input logic el, input logic er);
      logic rr;
      do_cmd(CMD_TOK_RD, {10'h155, i[2:0]}, 9'h000);
      rr = ~dev_u.own[1][i];
      check(rsp_rdata, {DATA_W{el}});
      check({8'h00, rr}, {8'h00, er});
   endtask : tok_chk
   task automatic tok_step(input int i, input logic b, input logic el, input logic er);
      do_cmd(CMD_TOK_WR, {10'h2aa, i[2:0]}, {8'hff, b});
      tok_chk(i, el, er);
   endtask : tok_step
   task automatic give_verdict();
      $display("checks=%0d errors=%0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   initial begin
      #(2_000_000);
      n_errors++;
      give_verdict();
   end
   task automatic run_init();
      // tokens start held by this side; the init sequence must free them
      init_tokens <= 1'b1;
      for (int n = 0; n < 8 && cmd_ready !== 1'b0; n++) @(negedge sys_clk);
      @(posedge sys_clk);
      init_tokens <= 1'b0;
      for (int i = 0; i < TOKEN_COUNT; i++) dev_u.tok_wr(1, i, 1'b1);
      for (int i = 0; i < TOKEN_COUNT; i++) tok_chk(i, 1'b1, 1'b1);
   endtask : run_init
   task automatic run_mem();
      foreach (ads[k]) do_cmd(CMD_MEM_WR, ads[k], ads[k][8:0] ^ 9'h155);
      check(9'(rsp_busy_hit), 9'h000);
      foreach (ads[k]) begin
         do_cmd(CMD_MEM_RD, ads[k], 9'h000);
         check(rsp_rdata, ads[k][8:0] ^ 9'h155);
      end
   endtask : run_mem
   task automatic run_mailbox();
      wait_pend(1'b0);
      do_cmd(CMD_MEM_WR, MBX_TO_RIGHT, 9'h0a5);
      check(9'(dev_u.right_flag_b), 9'h000);
      dev_u.right_mem_rd(MBX_TO_RIGHT);
      check(9'(dev_u.right_flag_b), 9'h001);
      dev_u.right_mem_wr(MBX_TO_LEFT, 9'h13c);
      wait_pend(1'b1);
      do_cmd(CMD_MEM_RD, MBX_TO_LEFT, 9'h000);
      check(rsp_rdata, 9'h13c);
      wait_pend(1'b0);
   endtask : run_mailbox
   task automatic run_tokens();
      for (int i = 0; i < TOKEN_COUNT; i++) begin
         tok_step(i, 1'b0, 1'b0, 1'b1);
         dev_u.tok_wr(1, i, 1'b0);
         tok_step(i, 1'b1, 1'b1, 1'b0);
         tok_step(i, 1'b0, 1'b1, 1'b0);
         dev_u.tok_wr(1, i, 1'b1);
         tok_chk(i, 1'b0, 1'b1);
         tok_step(i, 1'b1, 1'b1, 1'b1);
      end
   endtask : run_tokens
   task automatic run_busy();
      do_cmd(CMD_MEM_WR, 13'h0123, 9'h0f0);
      dev_u.busy_in_b = 1'b0;
      repeat (4) @(negedge sys_clk);
      do_cmd(CMD_MEM_WR, 13'h0123, 9'h10f);
      check(9'(rsp_busy_hit), 9'h001);
      check(9'(dev_u.busy_wr), 9'h000);
      dev_u.busy_in_b = 1'b1;
      repeat (4) @(negedge sys_clk);
      do_cmd(CMD_MEM_RD, 13'h0123, 9'h000);
      check(rsp_rdata, 9'h0f0);
   endtask : run_busy
   initial begin
      // a real falling edge at time zero so the asynchronous reset takes hold at once
      rst_b <= 1'b0;
      repeat (10) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge sys_clk);
      run_init();
      run_mem();
      run_mailbox();
      run_tokens();
      run_busy();
      check(9'(dev_u.illegal), 9'h000);
      check(9'(dev_u.gap_bad), 9'h000);
      give_verdict();
   end
endmodule : dpmbx_host_tb_top
